// [core/adc_status_flag_logic.sv]
// adc status flags, result registers and avalon-mm register slave
`timescale 1ns/1ps
module adc_status_flag_logic #(
  parameter int NCH = adc_flag_pkg::NUM_CH,
  parameter int RW = adc_flag_pkg::RES_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // conversion core
  input wire logic conv_eoc,
  input wire logic [$clog2(NCH)-1:0] conv_ch,
  input wire logic [RW-1:0] conv_data,
  output logic conv_start,
  output logic [NCH-1:0] chan_enable,
  output logic conv_sleep,
  // interrupt
  output logic irq
);
  import adc_flag_pkg::*;
  localparam int CW = $clog2(NCH);

  // registers
  logic [NCH-1:0] chen_r;
  logic sleep_cfg_r;
  logic asleep_r;
  logic start_r;
  logic data_ready_flag_r;
  logic govr_r;
  logic [RW-1:0] last_data_r;
  logic [CW-1:0] last_ch_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [NCH-1:0] done_w;
  logic [NCH-1:0] ovr_w;
  logic [RW-1:0] store_rd;

  // bus decode
  wire acc = (avs_read | avs_write) & ~ack_r;
  wire rd = avs_read & ~ack_r;
  wire wr = avs_write & ~ack_r;
  wire wr_ctrl = wr && avs_address == OFF_CTRL;
  wire wr_mode = wr && avs_address == OFF_MODE;
  wire wr_chen = wr && avs_address == OFF_CHEN;
  wire wr_chdis = wr && avs_address == OFF_CHDIS;
  wire wr_imask = wr && avs_address == OFF_IRQ_MASK;
  wire wr_istat = wr && avs_address == OFF_IRQ_STAT;
  wire rd_status = rd && avs_address == OFF_STATUS;
  wire rd_last = rd && avs_address == OFF_LAST;
  wire in_res = avs_address >= OFF_RESULT0 &&
                avs_address < OFF_RESULT0 + 8'(4 * NCH) &&
                avs_address[1:0] == 2'b00;
  wire [7:0] res_off = avs_address - OFF_RESULT0;
  wire [CW-1:0] res_ch = res_off[CW+1:2];
  wire rd_res = rd && in_res;

  // conversion end qualified by the channel's enable at that moment
  wire ch_en_now = chen_r[conv_ch];
  wire eoc_ok = conv_eoc & ch_en_now;

  // per-channel done and overrun flags
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire clr_d = (rd_res && res_ch == CW'(g)) ||
                   (rd_last && last_ch_r == CW'(g));
      adc_chan_flags u_flags (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .eoc_ev(conv_eoc && conv_ch == CW'(g)),
        .enabled(chen_r[g]),
        .clr_done(clr_d),
        .clr_ovr(rd_status),
        .done_r(done_w[g]),
        .ovr_r(ovr_w[g])
      );
    end
  endgenerate

  // result array
  adc_result_store #(.NCH(NCH), .RW(RW)) u_store (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(eoc_ok),
    .wr_ch(conv_ch),
    .wr_data(conv_data),
    .rd_ch(res_ch),
    .rd_data(store_rd)
  );

  // global flags: set independent of reads or disables elsewhere
  wire data_ready_flag_set = eoc_ok;
  wire govr_set = eoc_ok & data_ready_flag_r;
  wire data_ready_flag_nxt = data_ready_flag_set | (data_ready_flag_r & ~rd_last);
  wire govr_nxt = govr_set | (govr_r & ~rd_status);
  wire any_ovr_set = eoc_ok & done_w[conv_ch];

  // channel enable set/clear
  wire [NCH-1:0] chen_nxt = wr_chen ? (chen_r | avs_writedata[NCH-1:0]) :
                            wr_chdis ? (chen_r & ~avs_writedata[NCH-1:0]) :
                            chen_r;

  // sleep entered only at a conversion end, left on clearing the setting
  wire asleep_nxt = (sleep_cfg_r & conv_eoc) |
                    (asleep_r & sleep_cfg_r);

  // interrupt events
  wire [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_EOC_BIT] = eoc_ok;
  assign irq_ev[IRQ_DATA_READY_FLAG_BIT] = data_ready_flag_set;
  assign irq_ev[IRQ_GOVR_BIT] = govr_set;
  assign irq_ev[IRQ_OVR_BIT] = any_ovr_set;
  wire [IRQ_W-1:0] istat_clr = wr_istat ? avs_writedata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] istat_nxt = irq_ev | (irq_stat_r & ~istat_clr);

  // read mux
  wire [31:0] status_w = {13'h0, asleep_r, govr_r, data_ready_flag_r,
                          8'(ovr_w), 8'(done_w)};
  wire [31:0] last_w = {16'h0, 4'(last_ch_r), 12'(last_data_r)};
  wire [31:0] rdata_nxt =
    (avs_address == OFF_MODE) ? 32'(sleep_cfg_r) << MODE_SLEEP_BIT :
    (avs_address == OFF_CHSTAT) ? 32'(chen_r) :
    (avs_address == OFF_STATUS) ? status_w :
    (avs_address == OFF_LAST) ? last_w :
    (avs_address == OFF_IRQ_STAT) ? 32'(irq_stat_r) :
    (avs_address == OFF_IRQ_MASK) ? 32'(irq_mask_r) :
    in_res ? 32'(store_rd) : UNMAPPED_VAL;

  // outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  assign chan_enable = chen_r;
  assign conv_start = start_r;
  assign conv_sleep = asleep_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  // bus handshake: one wait cycle then acknowledge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdata_r <= RST_ZERO;
    end else begin
      ack_r <= acc;
      if (rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // control registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chen_r <= '0;
      sleep_cfg_r <= 1'b0;
      start_r <= 1'b0;
      irq_mask_r <= '0;
    end else begin
      chen_r <= chen_nxt;
      start_r <= wr_ctrl & avs_writedata[CTRL_START_BIT];
      if (wr_mode) begin
        sleep_cfg_r <= avs_writedata[MODE_SLEEP_BIT];
      end
      if (wr_imask) begin
        irq_mask_r <= avs_writedata[IRQ_W-1:0];
      end
    end
  end

  // status flags and last result
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ready_flag_r <= 1'b0;
      govr_r <= 1'b0;
      asleep_r <= 1'b0;
      irq_stat_r <= '0;
      last_data_r <= '0;
      last_ch_r <= '0;
    end else begin
      data_ready_flag_r <= data_ready_flag_nxt;
      govr_r <= govr_nxt;
      asleep_r <= asleep_nxt;
      irq_stat_r <= istat_nxt;
      if (eoc_ok) begin
        last_data_r <= conv_data;
        last_ch_r <= conv_ch;
      end
    end
  end
endmodule // adc_status_flag_logic

// [core/adc_flag_pkg.sv]
// package: register map, field layout and reset values of the adc flag logic
package adc_flag_pkg;
  localparam int NUM_CH = 8;
  localparam int RES_W = 10;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CHEN = 8'h10;
  localparam logic [7:0] OFF_CHDIS = 8'h14;
  localparam logic [7:0] OFF_CHSTAT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_LAST = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_RESULT0 = 8'h30;
  // field positions
  localparam int CTRL_START_BIT = 1;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int ST_OVR_LSB = 8;
  localparam int ST_DATA_READY_FLAG_BIT = 16;
  localparam int ST_GOVR_BIT = 17;
  localparam int ST_ASLEEP_BIT = 18;
  localparam int LAST_CH_LSB = 12;
  // interrupt status bits
  localparam int IRQ_EOC_BIT = 0;
  localparam int IRQ_DATA_READY_FLAG_BIT = 1;
  localparam int IRQ_GOVR_BIT = 2;
  localparam int IRQ_OVR_BIT = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
endpackage

// [core/adc_chan_flags.sv]
// per-channel conversion-done and overrun flags
`timescale 1ns/1ps
module adc_chan_flags (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // events
  input wire logic eoc_ev,
  input wire logic enabled,
  input wire logic clr_done,
  input wire logic clr_ovr,
  // flags
  output logic done_r,
  output logic ovr_r
);
  import adc_flag_pkg::*;
  logic set_done;
  logic set_ovr;
  logic done_nxt;
  logic ovr_nxt;
  // a disabled channel never raises its done flag
  assign set_done = eoc_ev & enabled;
  assign set_ovr = set_done & done_r;
  // set beats clear
  assign done_nxt = set_done | (done_r & ~clr_done);
  assign ovr_nxt = set_ovr | (ovr_r & ~clr_ovr);
  // flag registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      ovr_r <= ovr_nxt;
    end
  end
endmodule // adc_chan_flags

// [core/adc_result_store.sv]
// per-channel result storage array
`timescale 1ns/1ps
module adc_result_store #(
  parameter int NCH = adc_flag_pkg::NUM_CH,
  parameter int RW = adc_flag_pkg::RES_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(NCH)-1:0] wr_ch,
  input wire logic [RW-1:0] wr_data,
  // read side
  input wire logic [$clog2(NCH)-1:0] rd_ch,
  output logic [RW-1:0] rd_data
);
  import adc_flag_pkg::*;
  logic [RW-1:0] mem_r [NCH];
  assign rd_data = mem_r[rd_ch];
  // store one result per channel
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NCH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wr_en) begin
      mem_r[wr_ch] <= wr_data;
    end
  end
endmodule // adc_result_store

// [verif/adc_status_flag_logic_chk.sv]
// checker: bus, enable, start and sleep relations at the ports
`timescale 1ns/1ps
module adc_status_flag_logic_chk #(
  parameter int NCH = adc_flag_pkg::NUM_CH,
  parameter int RW = adc_flag_pkg::RES_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // core side
  input wire logic conv_eoc,
  input wire logic [$clog2(NCH)-1:0] conv_ch,
  input wire logic [RW-1:0] conv_data,
  input wire logic conv_start,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic conv_sleep,
  input wire logic irq
);
  import adc_flag_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // request taken and answered
  wire req = avs_read | avs_write;
  wire wr_t = avs_write & avs_waitrequest;
  sequence taken_s; req && avs_waitrequest; endsequence
  sequence ack_s; req && !avs_waitrequest; endsequence
  wait_ack_a: assert property ($rose(req) |-> taken_s ##1 ack_s)
    else $error("request not answered in one cycle");
  rdata_hold_a: assert property
    (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property
    (avs_read && avs_waitrequest && avs_address >= 8'h50
     |=> avs_readdata == UNMAPPED_VAL)
    else $error("unmapped read not zero");
  start_pulse_a: assert property (
    wr_t && avs_address == OFF_CTRL && avs_writedata[CTRL_START_BIT]
    |=> conv_start ##1 !conv_start)
    else $error("start pulse wrong");
  sleep_eoc_a: assert property ($rose(conv_sleep) |-> $past(conv_eoc))
    else $error("sleep entered without conversion end");
  sleep_hold_a: assert property (conv_sleep && !avs_write |=> conv_sleep)
    else $error("sleep left without a write");
  chen_set_a: assert property (wr_t && avs_address == OFF_CHEN
    |=> chan_enable == ($past(chan_enable) | $past(avs_writedata[NCH-1:0])))
    else $error("enable set wrong");
  chdis_clr_a: assert property (wr_t && avs_address == OFF_CHDIS
    |=> chan_enable == ($past(chan_enable) & ~$past(avs_writedata[NCH-1:0])))
    else $error("disable wrong");
endmodule // adc_status_flag_logic_chk

// [verif/adc_core_model.sv]
// conversion core model: end-of-conversion pulses
`timescale 1ns/1ps
module adc_core_model (
  // clock and start
  input wire logic sys_clk,
  input wire logic conv_start,
  // results
  output logic conv_eoc,
  output logic [2:0] conv_ch,
  output logic [adc_flag_pkg::RES_W-1:0] conv_data
);
  import adc_flag_pkg::*;
  initial begin
    conv_eoc = 1'b0;
    conv_ch = 3'h0;
    conv_data = 10'h000;
  end
  // one pulse, then data lines show the inverse
  task automatic pulse(input logic [2:0] c, input logic [9:0] d);
    @(posedge sys_clk);
    conv_eoc <= 1'b1;
    conv_ch <= c;
    conv_data <= d;
    @(posedge sys_clk);
    conv_eoc <= 1'b0;
    conv_data <= ~d;
  endtask
  // a start ends in a channel 0 conversion
  always @(posedge sys_clk) begin
    if (conv_start) begin
      repeat (3) @(posedge sys_clk);
      pulse(3'h0, 10'h2aa);
    end
  end
endmodule // adc_core_model

// [verif/adc_status_flag_logic_bench.sv]
// bench: register, collision, interrupt and sleep tests
`timescale 1ns/1ps
module adc_status_flag_logic_bench;
  import adc_flag_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, conv_eoc, conv_start, conv_sleep, irq;
  logic [2:0] conv_ch;
  logic [9:0] conv_data;
  logic [7:0] chan_enable;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  adc_status_flag_logic i_adc_status_flag_logic (.*);
  adc_core_model i_adc_core_model (.*);
  initial forever #10 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g & m, e & m);
    end
  endtask
  // one transfer held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    xfer(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic eoc(input logic [2:0] c, input logic [9:0] d);
    i_adc_core_model.pulse(c, d);
  endtask
  // read whose sampling edge meets a conversion end
  task automatic rd_eoc(input logic [7:0] a, input logic [31:0] e, m,
                        input logic [2:0] c, input logic [9:0] d);
    fork
      rd(a, e, m);
      eoc(c, d);
    join
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(OFF_STATUS, RST_ZERO, '1);
    wr(OFF_CHEN, 32'h07);
    rd(OFF_CHSTAT, 32'h07, 32'hff);
    eoc(3'h0, 10'h155);
    rd(OFF_STATUS, 32'h1_0001, '1);
    rd(OFF_RESULT0, 32'h155, '1);
    rd(OFF_STATUS, 32'h1_0000, '1);
    rd(OFF_LAST, 32'h0155, '1);
    rd(OFF_STATUS, RST_ZERO, '1);
    $display("plain conversion test done");
    rd_eoc(OFF_RESULT0 + 8'h04, 32'h0, '1, 3'h0, 10'h0aa);
    rd(OFF_STATUS, 32'h1_0001, '1);
    rd_eoc(OFF_STATUS, 32'h1_0001, '1, 3'h1, 10'h011);
    rd(OFF_STATUS, 32'h3_0003, '1);
    rd(OFF_STATUS, 32'h1_0003, '1);
    fork
      wr(OFF_CHDIS, 32'h04);
      eoc(3'h1, 10'h022);
    join
    rd(OFF_STATUS, 32'h3_0202, 32'h3_0202);
    rd_eoc(OFF_RESULT0, 32'h0aa, '1, 3'h0, 10'h033);
    rd(OFF_STATUS, 32'h2_0001, 32'h2_0001);
    eoc(3'h1, 10'h044);
    rd(OFF_RESULT0 + 8'h04, 32'h044, '1);
    rd_eoc(OFF_STATUS, 32'h3_0201, '1, 3'h1, 10'h055);
    rd(OFF_STATUS, 32'h0002, 32'h0202);
    rd_eoc(OFF_RESULT0, 32'h033, '1, 3'h2, 10'h3ff);
    rd(OFF_STATUS, 0, 32'h0004);
    rd(OFF_CHSTAT, 32'h03, 32'hff);
    rd(OFF_LAST, 32'h1055, 32'hf3ff);
    $display("collision tests done");
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_IRQ_STAT, 32'hf);
    eoc(3'h0, 10'h066);
    rd(OFF_IRQ_STAT, 32'h3, 32'h3);
    chk({31'h0, irq}, 0, 1);
    wr(OFF_IRQ_MASK, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, irq}, 1, 1);
    rd(OFF_LAST, 32'h0066, 32'hf3ff);
    wr(OFF_IRQ_STAT, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, irq}, 0, 1);
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, UNMAPPED_VAL, '1);
    $display("interrupt and map test done");
    wr(OFF_MODE, 32'h20);
    repeat (5) @(negedge sys_clk);
    chk({31'h0, conv_sleep}, 0, 1);
    wr(OFF_CTRL, 32'h2);
    repeat (8) @(negedge sys_clk);
    chk({31'h0, conv_sleep}, 1, 1);
    $display("sleep test done");
    report_and_stop();
  end
endmodule // adc_status_flag_logic_bench
bind adc_status_flag_logic adc_status_flag_logic_chk #(.NCH(NCH), .RW(RW))
  i_adc_status_flag_logic_chk (.*);
